// ===== crtc_cmd_port.sv
// command, parameter and status port of a raster text display controller
// bus strobes and raster position come from logic on mclk_i; the pen strobe is asynchronous
`timescale 1ns/1ps
module crtc_cmd_port
	import crtc_pkg::*;
(
	input  wire logic         mclk_i,
	input  wire logic         resetn_i,
	input  wire logic         port_select_i,
	input  wire logic         rd_i,
	input  wire logic         wr_i,
	input  wire logic [7:0]   data_i,
	input  wire logic         pen_strobe_in_i,
	input  wire logic [6:0]   char_pos_i,
	input  wire logic [5:0]   row_pos_i,
	input  wire logic         frame_start_i,
	input  wire logic         last_row_i,
	input  wire logic         dma_underrun_i,
	input  wire logic         fifo_overrun_i,
	input  wire logic         field_rev_i,
	input  wire logic         field_ul_i,
	output logic [7:0]        data_o,
	output logic              video_suppress_out_o,
	output logic              dma_enable_o,
	output logic              int_enable_o,
	output logic              preset_o,
	output logic              rev_video_o,
	output logic              underline_o,
	output crtc_fmt_type      fmt_o
);
	typedef struct packed {
		crtc_phase_type phase;
		logic [2:0]     remain;
		crtc_fmt_type   fmt;
		logic [6:0]     cur_char;
		logic [5:0]     cur_row;
		logic [6:0]     pen_char;
		logic [5:0]     pen_row;
		logic           ie;
		logic           ir;
		logic           lp;
		logic           ic;
		logic           ve;
		logic           du;
		logic           fo;
		logic           dma;
		logic           preset;
		logic [BLINK_BITS-1:0] blink;
		logic [2:0]     sync;
		logic           pen_lvl;
		logic [7:0]     rdata;
		logic           rvv;
		logic           ltn;
		logic           video_suppress_out;
	} crtc_state_type;

	crtc_state_type q, d;
	logic           cmd_wr, par_wr, stat_rd, par_rd;
	logic           pen_rise, cur_hit, cur_vis, cur_rev, cur_ul;
	logic [2:0]     byte_idx;
	logic [2:0]     opcode;
	logic [7:0]     status;

	assign cmd_wr  = wr_i && port_select_i == PORT_CMD_STAT;
	assign par_wr  = wr_i && port_select_i == PORT_PARAM;
	assign stat_rd = rd_i && port_select_i == PORT_CMD_STAT;
	assign par_rd  = rd_i && port_select_i == PORT_PARAM;
	assign opcode  = data_i[CMD_MSB:CMD_LSB];
	assign byte_idx = NPAR_FORMAT - q.remain;
	// edge counts once the second and third stages agree
	assign pen_rise = (q.sync[1] == q.sync[2]) && q.sync[2] && !q.pen_lvl;
	assign cur_hit = char_pos_i == q.cur_char && row_pos_i == q.cur_row;
	assign cur_vis = cur_hit && (q.fmt.cursor_style[1] || !q.blink[BLINK_BITS-1]);
	assign cur_rev = cur_vis && !q.fmt.cursor_style[0];
	assign cur_ul  = cur_vis && q.fmt.cursor_style[0];
	assign status  = {1'b0, q.ie, q.ir, q.lp, q.ic, q.ve, q.du, q.fo};

	always_comb begin
		d = q;
		d.sync = {q.sync[1:0], pen_strobe_in_i};
		if (q.sync[1] == q.sync[2]) begin
			d.pen_lvl = q.sync[2];
		end
		if (frame_start_i) begin
			d.blink = q.blink + 4'h1;
		end
		// reversals cancel; underline merges into the field's own
		d.rvv = field_rev_i ^ cur_rev;
		d.ltn = field_ul_i | cur_ul;
		// read clears sticky flags, a same-cycle event wins
		if (stat_rd) begin
			d.rdata = status;
			d.ir = 1'b0;
			d.lp = 1'b0;
			d.ic = 1'b0;
			d.du = 1'b0;
			d.fo = 1'b0;
		end
		if (par_rd) begin
			d.rdata = 8'h00;
			if (q.phase == PH_PEN && q.remain != NPAR_NONE) begin
				d.rdata = (q.remain == NPAR_TWO) ? {1'b0, q.pen_char} : {2'h0, q.pen_row};
				d.remain = q.remain - 3'h1;
			end
		end
		if (cmd_wr) begin
			if (q.remain != NPAR_NONE) begin
				d.ic = 1'b1;
			end
			d.preset = 1'b0;
			d.remain = NPAR_NONE;
			d.phase = PH_IDLE;
			unique case (opcode)
				CMD_RESET: begin
					d.phase = PH_FORMAT;
					d.remain = NPAR_FORMAT;
					d.dma = 1'b0;
					d.ie = 1'b0;
					d.ve = 1'b0;
				end
				CMD_START: begin
					d.ie = 1'b1;
					d.dma = 1'b1;
					d.ve = 1'b1;
				end
				CMD_STOP: begin
					d.ve = 1'b0;
				end
				CMD_PEN: begin
					d.phase = PH_PEN;
					d.remain = NPAR_TWO;
				end
				CMD_CURSOR: begin
					d.phase = PH_CURSOR;
					d.remain = NPAR_TWO;
				end
				CMD_INT_ON: begin
					d.ie = 1'b1;
				end
				CMD_INT_OFF: begin
					d.ie = 1'b0;
				end
				CMD_PRESET: begin
					d.preset = 1'b1;
				end
			endcase
		end
		if (par_wr) begin
			if (q.remain == NPAR_NONE || q.phase == PH_PEN) begin
				d.ic = 1'b1;
			end else begin
				d.remain = q.remain - 3'h1;
				if (q.phase == PH_CURSOR) begin
					if (q.remain == NPAR_TWO) begin
						d.cur_char = data_i[6:0];
					end else begin
						d.cur_row = data_i[5:0];
					end
				end else begin
					unique case (byte_idx)
						3'h0: begin
							d.fmt.spaced = data_i[F_SPACED];
							d.fmt.chars = {1'b0, data_i[6:0]} + 8'h01;
						end
						3'h1: begin
							d.fmt.vrows = {1'b0, data_i[7:F_VROWS_LSB]} + 3'h1;
							d.fmt.rows = {1'b0, data_i[5:0]} + 7'h01;
						end
						3'h2: begin
							d.fmt.blank_edges = data_i[7];
							d.fmt.ul_line = {1'b0, data_i[7:F_UL_LSB]} + 5'h01;
							d.fmt.lines = {1'b0, data_i[3:0]} + 5'h01;
						end
						default: begin
							d.fmt.line_mode = data_i[F_LINE_MODE];
							d.fmt.attr_mode = data_i[F_ATTR_MODE];
							d.fmt.cursor_style = data_i[5:F_CURSOR_LSB];
							d.fmt.hrt = {1'b0, data_i[3:0], 1'b0} + 6'h02;
						end
					endcase
				end
			end
		end
		// position lags the beam; software applies the correction
		if (pen_rise) begin
			d.pen_char = char_pos_i;
			d.pen_row = row_pos_i;
			d.lp = 1'b1;
		end
		if (last_row_i && q.ie) begin
			d.ir = 1'b1;
		end
		if (dma_underrun_i) begin
			d.du = 1'b1;
		end
		if (fifo_overrun_i) begin
			d.fo = 1'b1;
		end
		d.video_suppress_out = !d.ve;
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '{phase: PH_IDLE, fmt: FMT_RESET, video_suppress_out: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	assign data_o = q.rdata;
	assign video_suppress_out_o = q.video_suppress_out;
	assign dma_enable_o = q.dma;
	assign int_enable_o = q.ie;
	assign preset_o = q.preset;
	assign rev_video_o = q.rvv;
	assign underline_o = q.ltn;
	assign fmt_o = q.fmt;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	chk_pen_capture: assert property (
		pen_rise |=> q.lp && q.pen_char == $past(char_pos_i) && q.pen_row == $past(row_pos_i))
		else $error("pen position not captured");
	chk_status_value: assert property (
		stat_rd |=> data_o == {1'b0, $past(q.ie), $past(q.ir), $past(q.lp), $past(q.ic),
			$past(q.ve), $past(q.du), $past(q.fo)})
		else $error("status read returned wrong value");
	chk_short_string: assert property (
		cmd_wr && q.remain != NPAR_NONE |=> q.ic)
		else $error("short parameter string not flagged");
	chk_flag_holds: assert property (
		q.ic && !stat_rd |=> q.ic)
		else $error("improper flag lost without status read");
	chk_reset_blank: assert property (
		cmd_wr && opcode == CMD_RESET |=> video_suppress_out_o && !dma_enable_o
			&& !int_enable_o && q.remain == NPAR_FORMAT)
		else $error("reset command did not stop display");
	chk_start_enable: assert property (
		cmd_wr && opcode == CMD_START |=> !video_suppress_out_o && dma_enable_o
			&& status[ST_IE] && status[ST_VE])
		else $error("start command did not enable display");
	chk_surplus_drop: assert property (
		par_wr && q.remain == NPAR_NONE |=> $stable(q.fmt) && q.ic)
		else $error("surplus parameter altered format");
	chk_retrace_width: assert property (
		par_wr && q.phase == PH_FORMAT && q.remain == 3'h1
			|=> fmt_o.hrt == ({2'h0, $past(data_i[3:0])} + 6'h01) * 6'h02)
		else $error("horizontal retrace width wrong");
	chk_cursor_cancel: assert property (
		cur_hit && q.fmt.cursor_style == CUR_STEADY_REV && field_rev_i |=> !rev_video_o)
		else $error("steady block cursor did not cancel reverse field");
	chk_underline_merge: assert property (
		cur_hit && q.fmt.cursor_style == CUR_STEADY_UL && field_ul_i |=> underline_o)
		else $error("steady underline cursor altered underline field");
	chk_rows_count: assert property (
		par_wr && q.phase == PH_FORMAT && q.remain == 3'h3
			|=> fmt_o.rows == {1'b0, $past(data_i[5:0])} + 7'h01)
		else $error("rows per frame wrong");
	chk_cmd_write_only: assert property (
		cmd_wr |=> $stable(data_o))
		else $error("command write disturbed read data");
	chk_idle_param_read: assert property (
		par_rd && q.remain == NPAR_NONE |=> data_o == 8'h00)
		else $error("parameter read outside pen phase not zero");
	chk_pen_char_read: assert property (
		par_rd && q.phase == PH_PEN && q.remain == NPAR_TWO
			|=> data_o == {1'b0, $past(q.pen_char)})
		else $error("first pen parameter wrong");
	chk_pen_row_read: assert property (
		par_rd && q.phase == PH_PEN && q.remain == 3'h1
			|=> data_o == {2'h0, $past(q.pen_row)} && q.remain == NPAR_NONE)
		else $error("second pen parameter wrong");
	chk_cursor_char: assert property (
		par_wr && q.phase == PH_CURSOR && q.remain == NPAR_TWO
			|=> q.cur_char == $past(data_i[6:0]))
		else $error("cursor character not loaded");
	chk_cursor_row: assert property (
		par_wr && q.phase == PH_CURSOR && q.remain == 3'h1
			|=> q.cur_row == $past(data_i[5:0]))
		else $error("cursor row not loaded");
	chk_pen_write_flag: assert property (
		par_wr && q.phase == PH_PEN |=> q.ic)
		else $error("parameter write in pen phase not flagged");
	chk_row_spacing: assert property (
		par_wr && q.phase == PH_FORMAT && q.remain == NPAR_FORMAT
			|=> fmt_o.spaced == $past(data_i[F_SPACED]))
		else $error("row spacing bit wrong");
	chk_chars_count: assert property (
		par_wr && q.phase == PH_FORMAT && q.remain == NPAR_FORMAT
			|=> fmt_o.chars == {1'b0, $past(data_i[6:0])} + 8'h01)
		else $error("characters per row wrong");
	chk_vert_retrace: assert property (
		par_wr && q.phase == PH_FORMAT && q.remain == 3'h3
			|=> fmt_o.vrows == {1'b0, $past(data_i[7:F_VROWS_LSB])} + 3'h1)
		else $error("vertical retrace rows wrong");
	chk_underline_line: assert property (
		par_wr && q.phase == PH_FORMAT && q.remain == NPAR_TWO
			|=> fmt_o.ul_line == {1'b0, $past(data_i[7:F_UL_LSB])} + 5'h01
			&& fmt_o.blank_edges == $past(data_i[7]))
		else $error("underline line or edge blanking wrong");
	chk_lines_count: assert property (
		par_wr && q.phase == PH_FORMAT && q.remain == NPAR_TWO
			|=> fmt_o.lines == {1'b0, $past(data_i[3:0])} + 5'h01)
		else $error("lines per row wrong");
	chk_line_mode: assert property (
		par_wr && q.phase == PH_FORMAT && q.remain == 3'h1
			|=> fmt_o.line_mode == $past(data_i[F_LINE_MODE]))
		else $error("line counter mode wrong");
	chk_attr_mode: assert property (
		par_wr && q.phase == PH_FORMAT && q.remain == 3'h1
			|=> fmt_o.attr_mode == $past(data_i[F_ATTR_MODE]))
		else $error("field attribute mode wrong");
	chk_cursor_style: assert property (
		par_wr && q.phase == PH_FORMAT && q.remain == 3'h1
			|=> fmt_o.cursor_style == $past(data_i[5:F_CURSOR_LSB]))
		else $error("cursor style wrong");
	chk_blink_hide: assert property (
		cur_hit && !q.fmt.cursor_style[1] && q.blink[BLINK_BITS-1] && !field_rev_i
			&& !field_ul_i |=> !rev_video_o && !underline_o)
		else $error("blinking cursor shown in its off phase");
	chk_stop_video: assert property (
		cmd_wr && opcode == CMD_STOP |=> video_suppress_out_o && $stable(int_enable_o))
		else $error("stop command handled wrongly");
	chk_preset_hold: assert property (
		cmd_wr && opcode == CMD_PRESET |=> preset_o)
		else $error("preset command not held");
endmodule

// ===== crtc_cmd_port_tb.sv
// self-checking bench for the command, parameter and status port
// assumes crtc_host as processor; the bench supplies raster and pen
`timescale 1ns/1ps
module crtc_cmd_port_tb;
	import crtc_pkg::*;
	logic         mclk_i;
	logic         resetn_i;
	logic         ps, rd, wr, pen, fs, frev, ful, lrow, du, fo;
	logic         video_suppress_out, dma, ie, pre, rev, ul;
	logic [7:0]   wd, rdata, st;
	logic [6:0]   cpos;
	logic [5:0]   rpos;
	crtc_fmt_type fmt;
	int           mismatches, n_checks, cycles;

	crtc_host u_crtc_host (.mclk_i(mclk_i), .rdata_i(rdata), .port_select_o(ps),
		.rd_o(rd), .wr_o(wr), .data_o(wd));
	crtc_cmd_port u_crtc_cmd_port (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.port_select_i(ps), .rd_i(rd), .wr_i(wr), .data_i(wd), .pen_strobe_in_i(pen),
		.char_pos_i(cpos), .row_pos_i(rpos), .frame_start_i(fs), .last_row_i(lrow),
		.dma_underrun_i(du), .fifo_overrun_i(fo), .field_rev_i(frev), .field_ul_i(ful),
		.data_o(rdata), .video_suppress_out_o(video_suppress_out), .dma_enable_o(dma),
		.int_enable_o(ie), .preset_o(pre), .rev_video_o(rev), .underline_o(ul),
		.fmt_o(fmt));

	task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic settle;
		repeat (2) @(posedge mclk_i);
		#1;
	endtask
	task automatic cmd(input logic [7:0] c);
		u_crtc_host.put(PORT_CMD_STAT, c);
		settle();
	endtask
	task automatic raster(input logic [6:0] c, input logic [5:0] r, input logic v, input logic u);
		@(posedge mclk_i);
		cpos <= c;
		rpos <= r;
		frev <= v;
		ful <= u;
		settle();
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic t_format;
		cmd(8'h20);
		u_crtc_host.format(32'hCFFF_FFEF);
		settle();
		chk("vsp", 1'b1, video_suppress_out);
		chk("dma", 1'b0, dma);
		chk("ie", 1'b0, ie);
		chk("fmt", {1'b1, 8'h50, 3'h4, 7'h40, 1'b1, 5'h10, 5'h10, 1'b1, 1'b1, 2'h2, 6'h20},
			fmt);
		u_crtc_host.get(PORT_CMD_STAT, st);
		chk("ic full format", 1'b0, st[ST_IC]);
		u_crtc_host.put(PORT_PARAM, 8'h00);
		settle();
		chk("fmt kept", {1'b1, 8'h50, 3'h4, 7'h40, 1'b1, 5'h10, 5'h10, 1'b1, 1'b1, 2'h2,
			6'h20}, fmt);
		u_crtc_host.get(PORT_CMD_STAT, st);
		chk("ic", 1'b1, st[ST_IC]);
		u_crtc_host.get(PORT_CMD_STAT, st);
		chk("ic cleared", 1'b0, st[ST_IC]);
	endtask
	task automatic t_cmds;
		cmd(8'h20);
		chk("vsp", 1'b0, video_suppress_out);
		chk("dma", 1'b1, dma);
		u_crtc_host.get(PORT_CMD_STAT, st);
		chk("status", 8'h44, st & 8'h44);
		cmd(8'h40);
		chk("vsp stop", 1'b1, video_suppress_out);
		chk("ie stop", 1'b1, ie);
		cmd(8'hC0);
		chk("ie off", 1'b0, ie);
		cmd(8'hA0);
		chk("ie on", 1'b1, ie);
		cmd(8'hE0);
		chk("preset", 1'b1, pre);
		cmd(8'h20);
		chk("preset end", 1'b0, pre);
	endtask
	task automatic t_improper;
		cmd(8'h80);
		u_crtc_host.put(PORT_PARAM, 8'h03);
		cmd(8'h20);
		u_crtc_host.get(PORT_CMD_STAT, st);
		chk("ic short", 1'b1, st[ST_IC]);
		cmd(8'h80);
		u_crtc_host.put(PORT_PARAM, 8'h03);
		u_crtc_host.put(PORT_PARAM, 8'h02);
		u_crtc_host.get(PORT_CMD_STAT, st);
		chk("ic full", 1'b0, st[ST_IC]);
	endtask
	task automatic t_pen;
		raster(7'h15, 6'h07, 1'b0, 1'b0);
		@(posedge mclk_i);
		pen <= 1'b1;
		repeat (8) @(posedge mclk_i);
		u_crtc_host.get(PORT_CMD_STAT, st);
		chk("lp", 1'b1, st[ST_LP]);
		cmd(8'h60);
		u_crtc_host.get(PORT_CMD_STAT, st);
		chk("lp read", 1'b0, st[ST_LP]);
		u_crtc_host.get(PORT_PARAM, st);
		chk("pen char", 8'h15, st);
		u_crtc_host.get(PORT_PARAM, st);
		chk("pen row", 8'h07, st);
		@(posedge mclk_i);
		pen <= 1'b0;
	endtask
	task automatic t_cursor;
		raster(7'h03, 6'h02, 1'b1, 1'b0);
		chk("rev cancel", 1'b0, rev);
		raster(7'h03, 6'h02, 1'b0, 1'b0);
		chk("rev block", 1'b1, rev);
		raster(7'h04, 6'h02, 1'b0, 1'b0);
		chk("rev off", 1'b0, rev);
		u_crtc_host.format(32'h0000_0030);
		raster(7'h03, 6'h02, 1'b0, 1'b1);
		chk("ul field", 1'b1, ul);
		raster(7'h03, 6'h02, 1'b0, 1'b0);
		chk("ul steady", 1'b1, ul);
		chk("ul rev", 1'b0, rev);
		u_crtc_host.format(32'h0000_0010);
		for (int k = 0; k < 2; k++) begin
			repeat (8) begin
				@(posedge mclk_i);
				fs <= 1'b1;
				@(posedge mclk_i);
				fs <= 1'b0;
			end
			settle();
			chk("blink", k[0], ul);
		end
	endtask

	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		resetn_i = 1'b0;
		{pen, fs, frev, ful, lrow, du, fo} = '0;
		cpos = '0;
		rpos = '0;
		repeat (5) @(posedge mclk_i);
		resetn_i <= 1'b1;
		settle();
		chk("vsp reset", 1'b1, video_suppress_out);
		chk("fmt reset", FMT_RESET, fmt);
		chk("data reset", 8'h00, rdata);
		chk("cursor reset", 1'b1, rev);
		t_format();
		t_cmds();
		t_improper();
		t_pen();
		t_cursor();
		wrap_up();
	end
endmodule

// ===== crtc_host.sv
// processor model driving the command, parameter and status port
// assumes the port samples its strobes on the rising edge of mclk_i
`timescale 1ns/1ps
module crtc_host
	import crtc_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic [7:0] rdata_i,
	output logic            port_select_o,
	output logic            rd_o,
	output logic            wr_o,
	output logic [7:0]      data_o
);
	initial begin
		port_select_o = 1'b0;
		rd_o = 1'b0;
		wr_o = 1'b0;
		data_o = 8'h00;
	end
	// released bus shows the inverted byte so a held value cannot pass
	task automatic put(input logic sel, input logic [7:0] d);
		@(posedge mclk_i);
		port_select_o <= sel;
		data_o <= d;
		wr_o <= 1'b1;
		@(posedge mclk_i);
		wr_o <= 1'b0;
		data_o <= ~d;
	endtask
	// read data is registered at the sampling edge
	task automatic get(input logic sel, output logic [7:0] d);
		@(posedge mclk_i);
		port_select_o <= sel;
		rd_o <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask
	task automatic format(input logic [31:0] b);
		put(PORT_CMD_STAT, 8'h00);
		for (int i = 3; i >= 0; i--) put(PORT_PARAM, b[i*8 +: 8]);
	endtask
endmodule

// ===== crtc_pkg.sv
// constants and types of the display controller command and format port
// assumes one character clock for every user of these definitions
package crtc_pkg;
	localparam logic       PORT_PARAM    = 1'b0;
	localparam logic       PORT_CMD_STAT = 1'b1;
	localparam int         CMD_MSB       = 7;
	localparam int         CMD_LSB       = 5;
	localparam logic [2:0] CMD_RESET     = 3'h0;
	localparam logic [2:0] CMD_START     = 3'h1;
	localparam logic [2:0] CMD_STOP      = 3'h2;
	localparam logic [2:0] CMD_PEN       = 3'h3;
	localparam logic [2:0] CMD_CURSOR    = 3'h4;
	localparam logic [2:0] CMD_INT_ON    = 3'h5;
	localparam logic [2:0] CMD_INT_OFF   = 3'h6;
	localparam logic [2:0] CMD_PRESET    = 3'h7;
	localparam logic [2:0] NPAR_FORMAT   = 3'h4;
	localparam logic [2:0] NPAR_TWO      = 3'h2;
	localparam logic [2:0] NPAR_NONE     = 3'h0;
	localparam int         ST_IE         = 6;
	localparam int         ST_IR         = 5;
	localparam int         ST_LP         = 4;
	localparam int         ST_IC         = 3;
	localparam int         ST_VE         = 2;
	localparam int         ST_DU         = 1;
	localparam int         ST_FO         = 0;
	localparam int         F_SPACED      = 7;
	localparam int         F_VROWS_LSB   = 6;
	localparam int         F_UL_LSB      = 4;
	localparam int         F_LINE_MODE   = 7;
	localparam int         F_ATTR_MODE   = 6;
	localparam int         F_CURSOR_LSB  = 4;
	localparam int         BLINK_BITS    = 4;
	localparam logic [1:0] CUR_BLINK_REV = 2'h0;
	localparam logic [1:0] CUR_BLINK_UL  = 2'h1;
	localparam logic [1:0] CUR_STEADY_REV = 2'h2;
	localparam logic [1:0] CUR_STEADY_UL = 2'h3;

	typedef enum logic [1:0] {PH_IDLE, PH_FORMAT, PH_CURSOR, PH_PEN} crtc_phase_type;

	typedef struct packed {
		logic       spaced;
		logic [7:0] chars;
		logic [2:0] vrows;
		logic [6:0] rows;
		logic       blank_edges;
		logic [4:0] ul_line;
		logic [4:0] lines;
		logic       line_mode;
		logic       attr_mode;
		logic [1:0] cursor_style;
		logic [5:0] hrt;
	} crtc_fmt_type;

	localparam crtc_fmt_type FMT_RESET = '{1'b0, 8'h01, 3'h1, 7'h01, 1'b0, 5'h01,
		5'h01, 1'b0, 1'b0, 2'h0, 6'h02};
endpackage
